// >>> testbench/ssb_periph_model.sv
// Bus slave model that ends each transfer with a one-clock acknowledge
`timescale 1ns/1ps
module ssb_periph_model (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic [3:0]  LAT,
  input  wire logic [31:0] ADDR,
  input  wire logic        XFER_IN_PROGRESS_N,
  input  wire logic [7:0]  CS_N,
  output logic             XFER_ACK_N,
  output logic [31:0]      DATA_I
);
  logic [3:0]  cnt_q;
  logic [31:0] dat_q;

  // Released data lines show the inverse of the last word
  assign DATA_I = XFER_ACK_N ? ~dat_q : dat_q;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      dat_q <= 32'h0;
    end
    if (!RESETN || XFER_IN_PROGRESS_N || &CS_N) begin
      XFER_ACK_N <= 1'b1;
      cnt_q      <= 4'h0;
    end else if (!XFER_ACK_N) begin
      XFER_ACK_N <= 1'b1;
      cnt_q      <= 4'h0;
    end else if (cnt_q >= LAT) begin
      XFER_ACK_N <= 1'b0;
      dat_q      <= ADDR ^ 32'hc3c3_0000;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// >>> testbench/test_sync_system_bus_chip_select.sv
// Self-checking bench for the system bus master and its chip selects
`timescale 1ns/1ps
module test_sync_system_bus_chip_select;
  import ssb_pkg::*;
  localparam logic [31:0] KEY = 32'hc3c3_0000;
  localparam logic [31:0] GRP = 32'h1000_0000;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  size;
    logic        write;
    logic [1:0]  xtype;
    logic [2:0]  cs;
    logic [3:0]  lat;
  } ssb_row_t;

  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_ready;
  ssb_req_t    req = '0;
  logic        rsp_valid;
  ssb_rsp_t    rsp;
  ssb_cs_cfg_t cfg_cs [NUM_CS];
  logic [31:0] addr;
  logic [31:0] data_o;
  logic [31:0] data_i;
  logic        data_oe;
  logic        start_n;
  logic [1:0]  size;
  logic [1:0]  xtype;
  logic        rw;
  logic        tip_n;
  logic        ack_n;
  logic [7:0]  cs_n;
  logic        oe_n;
  logic        we_n;
  logic [1:0]  cs_port;
  logic [3:0]  lat = 4'h0;
  int          num_errors = 0;
  int          checks_done = 0;
  ssb_row_t    rows [12] = '{
    '{32'h8000_0000, SIZE_32, 1'b0, 2'h0, 3'h0, 4'h0},
    '{32'h8000_0000, SIZE_8, 1'b1, 2'h1, 3'h0, 4'h2},
    '{32'h4000_0100, SIZE_16, 1'b1, 2'h2, 3'h1, 4'h0},
    '{32'h4000_0100, SIZE_32, 1'b0, 2'h3, 3'h1, 4'h0},
    '{GRP + 32'h40, SIZE_LINE, 1'b0, 2'h0, 3'h2, 4'h1},
    '{GRP + 32'h20_0040, SIZE_LINE, 1'b1, 2'h1, 3'h3, 4'h0},
    '{GRP + 32'h40_0040, SIZE_32, 1'b1, 2'h0, 3'h4, 4'h0},
    '{GRP + 32'h40_0044, SIZE_16, 1'b0, 2'h1, 3'h4, 4'h3},
    '{GRP + 32'h60_0040, SIZE_LINE, 1'b0, 2'h3, 3'h5, 4'h0},
    '{GRP + 32'h80_0040, SIZE_LINE, 1'b1, 2'h2, 3'h6, 4'h2},
    '{GRP + 32'ha0_0044, SIZE_8, 1'b0, 2'h1, 3'h7, 4'h5},
    '{GRP + 32'ha0_0040, SIZE_32, 1'b0, 2'h0, 3'h7, 4'h0}};

  always #4 clock = ~clock;

  ssb_bus_master ssb_bus_master_i (
    .CLOCK(clock), .RESETN(resetn), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req),
    .RSP_VALID(rsp_valid), .RSP(rsp), .CFG_CS(cfg_cs), .CFG_GROUP_BASE(GRP), .ADDR(addr),
    .DATA_O(data_o), .DATA_OE(data_oe), .DATA_I(data_i), .XFER_START_N(start_n), .XFER_SIZE(size),
    .XFER_RW(rw), .XFER_TYPE(xtype), .XFER_IN_PROGRESS_N(tip_n), .XFER_ACK_N(ack_n), .CS_N(cs_n),
    .OE_N(oe_n), .WE_N(we_n), .CS_PORT(cs_port));

  ssb_periph_model ssb_periph_model_i (
    .CLOCK(clock), .RESETN(resetn), .LAT(lat), .ADDR(addr), .XFER_IN_PROGRESS_N(tip_n),
    .CS_N(cs_n), .XFER_ACK_N(ack_n), .DATA_I(data_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One request, then every bus cycle watched until all beats are answered
  task automatic run(input ssb_row_t r);
    int t0;
    int tot;
    int nrsp;
    int nst;
    int gap;
    int w;
    int est;
    t0 = -1;
    nst = 0;
    gap = 0;
    tot = (r.size == SIZE_LINE) ? 4 : 1;
    nrsp = tot;
    est = (cfg_cs[r.cs].wprot && r.write) ? 0 : ((tot == 4 && !cfg_cs[r.cs].burst_en) ? 4 : 1);
    w = cfg_cs[r.cs].ext_ack ? int'(r.lat) : int'(cfg_cs[r.cs].waits);
    lat <= r.lat;
    req <= '{r.addr, r.size, r.write, r.xtype, {4{~r.addr}}};
    req_valid <= 1'b1;
    do @(posedge clock); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    for (int n = 0; n < 100 && nrsp > 0; n++) begin
      #1;
      if (start_n === 1'b0) begin
        nst++;
        if (t0 < 0) begin
          t0 = n;
          check(addr, r.addr);
          check(size, tot == 4 ? (cfg_cs[r.cs].burst_en ? SIZE_LINE : SIZE_32) : r.size);
          check(rw, !r.write);
          check(xtype, r.xtype);
          check(tip_n, 1'b0);
          check(cs_n, 8'hff ^ (8'h01 << r.cs));
          check(cs_port, cfg_cs[r.cs].port);
          check(req_ready, 1'b0);
          check(data_oe, r.write);
          if (r.write) check(data_o, ~r.addr);
        end
      end
      if (t0 >= 0 && n == t0 + 1) begin
        check(oe_n, r.write);
        check(we_n, !r.write);
      end
      if (t0 >= 0 && tip_n === 1'b1 && nrsp > 1) gap++;
      if (rsp_valid === 1'b1) begin
        if (nrsp == tot && est > 0) check(n - t0, 2 + w);
        check(rsp.beat, tot - nrsp);
        check(rsp.last, nrsp == 1);
        check(rsp.err, est == 0);
        if (!r.write && cfg_cs[r.cs].ext_ack && (r.size == SIZE_32 || tot == 4)) begin
          check(rsp.data, (r.addr + 32'(4 * (tot - nrsp))) ^ KEY);
        end
        nrsp--;
      end
      @(posedge clock);
    end
    check(nrsp, 0);
    check(nst, est);
    if (tot == 4) check(gap == 0, est == 1);
  endtask

  initial begin
    for (int k = 0; k < NUM_CS; k++) cfg_cs[k] = '0;
    repeat (20) @(posedge clock);
    #1;
    check(addr, 32'h0);
    check({start_n, tip_n, cs_n, oe_n, we_n, rw, rsp_valid}, 14'h3ffe);
    @(posedge clock);
    resetn <= 1'b1;
    // Unprogrammed select zero answers a boot access
    run('{32'h0000_1000, SIZE_32, 1'b0, 2'h0, 3'h0, 4'h0});
    for (int k = 0; k < NUM_CS; k++) begin
      cfg_cs[k] <= '{32'h0, 32'h0, PORT_32, 4'h0, 1'b1, SPACE_ANY, k == 2 || k == 6, k == 4, 1'b1};
    end
    cfg_cs[0].base <= 32'h8000_0000;
    cfg_cs[0].mask <= 32'hff00_0000;
    cfg_cs[0].port <= PORT_16;
    cfg_cs[1].base <= 32'h4000_0100;
    cfg_cs[1].mask <= 32'hff00_0000;
    cfg_cs[1].ext_ack <= 1'b0;
    cfg_cs[1].waits <= WAIT_MAX;
    cfg_cs[3].ext_ack <= 1'b0;
    cfg_cs[3].waits <= 4'h2;
    @(posedge clock);
    foreach (rows[i]) run(rows[i]);
    // Reset in the middle of a burst returns the bus to idle
    lat <= 4'h5;
    req <= '{rows[4].addr, SIZE_LINE, 1'b0, 2'h0, {4{32'h0}}};
    req_valid <= 1'b1;
    repeat (3) @(posedge clock);
    req_valid <= 1'b0;
    resetn <= 1'b0;
    @(posedge clock);
    #1;
    check({start_n, tip_n, cs_n, rsp_valid}, 11'h7fe);
    @(posedge clock);
    resetn <= 1'b1;
    run(rows[4]);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    summarize();
  end
endmodule

// >>> verilog/ssb_bus_master.sv
// Synchronous system bus master with eight chip selects
`timescale 1ns/1ps
// How it works
// - Start strobe low one clock with address
// - Two-bit size field for 8/16/32 bits
// - Direction high on read, low on write
// - Two-bit transfer type with every address
// - In-progress asserted while any transfer runs
// - No new start until acknowledge released
// - Every transfer lasts at least two clocks
// - Burst is four 32-bit beats, unbroken in-progress
// - Bursts only for line fills and DMA
// - Per-select setting suppresses bursts
// - Eight chip selects plus output/write enables
// - Selects zero and one fully programmable
// - Select zero answers right after reset
// - Six selects decode fixed 2M blocks
// - Per-select width, waits, ack, space, burst, protect
// - Everything timed on one bus clock
// - 32-bit address and data buses
// - Memory-mapped only, no I/O cycles
module ssb_bus_master (
  input  wire logic                 CLOCK,
  input  wire logic                 RESETN,
  input  wire logic                 REQ_VALID,
  output logic                      REQ_READY,
  input  ssb_pkg::ssb_req_t         REQ,
  output logic                      RSP_VALID,
  output ssb_pkg::ssb_rsp_t         RSP,
  input  ssb_pkg::ssb_cs_cfg_t      CFG_CS [ssb_pkg::NUM_CS],
  input  wire logic [31:0]          CFG_GROUP_BASE,
  output logic [31:0]               ADDR,
  output logic [31:0]               DATA_O,
  output logic                      DATA_OE,
  input  wire logic [31:0]          DATA_I,
  output logic                      XFER_START_N,
  output logic [1:0]                XFER_SIZE,
  output logic                      XFER_RW,
  output logic [1:0]                XFER_TYPE,
  output logic                      XFER_IN_PROGRESS_N,
  input  wire logic                 XFER_ACK_N,
  output logic [ssb_pkg::NUM_CS-1:0] CS_N,
  output logic                      OE_N,
  output logic                      WE_N,
  output logic [1:0]                CS_PORT
);
  import ssb_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT, ST_NEXT} ssb_state_t;

  ssb_state_t            state_q;
  ssb_state_t            state_d;
  logic [NUM_CS-1:0]     hit;
  logic [2:0]            sel_idx;
  logic                  sel_any;
  ssb_cs_cfg_t           sel_cfg;
  logic                  accept;
  logic                  refuse;
  logic                  ack_now;
  logic                  beat_end;
  logic                  last_beat;
  logic [31:0]           addr_q;
  logic [1:0]            size_q;
  logic                  write_q;
  logic [1:0]            xtype_q;
  logic [127:0]          wdata_q;
  logic [1:0]            beat_q;
  logic                  line_q;
  logic                  burst_q;
  logic                  ext_q;
  logic                  sel_any_q;
  logic [2:0]            sel_q;
  logic [1:0]            port_q;
  logic [3:0]            waits_q;
  logic [3:0]            wcnt_q;
  logic [31:0]           data_o_q;
  ssb_rsp_t              rsp_q;
  logic                  rsp_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Chip-select decode

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CS; gi++) begin : g_cs
      ssb_cs_slot #(.IDX(gi)) u_slot (
        .cfg        (CFG_CS[gi]),
        .group_base (CFG_GROUP_BASE),
        .addr       (REQ.addr),
        .xtype      (REQ.xtype),
        .hit        (hit[gi])
      );
    end
  endgenerate

  // Lowest numbered select wins when windows overlap
  always_comb begin
    sel_idx = 3'h0;
    sel_any = 1'b0;
    for (int i = NUM_CS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        sel_idx = 3'(i);
        sel_any = 1'b1;
      end
    end
  end

  assign sel_cfg = CFG_CS[sel_idx];

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing

  // A new start waits for the acknowledge line to be released
  assign REQ_READY = (state_q == ST_IDLE) && XFER_ACK_N;
  assign accept    = REQ_VALID && REQ_READY;
  // Writes into a protected select never reach the bus
  assign refuse    = accept && REQ.write && sel_any && sel_cfg.wprot;

  // Termination comes from the peripheral or from the wait-state counter
  assign ack_now   = (state_q == ST_WAIT) &&
                     ((ext_q || !sel_any_q) ? !XFER_ACK_N : (wcnt_q == 4'h0));
  assign last_beat = !line_q || (beat_q == BEAT_LAST);
  assign beat_end  = ack_now;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  if (accept && !refuse) state_d = ST_START;
      ST_START: state_d = ST_WAIT;
      ST_WAIT: begin
        if (beat_end) begin
          if (last_beat) begin
            state_d = ST_IDLE;
          end else if (burst_q) begin
            state_d = ST_WAIT;
          end else begin
            state_d = ST_NEXT;
          end
        end
      end
      ST_NEXT:  if (XFER_ACK_N) state_d = ST_START;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Request capture and beat address
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      addr_q    <= 32'h0000_0000;
      size_q    <= SIZE_32;
      write_q   <= 1'b0;
      xtype_q   <= 2'h0;
      wdata_q   <= 128'h0;
      line_q    <= 1'b0;
      burst_q   <= 1'b0;
      ext_q     <= 1'b0;
      sel_any_q <= 1'b0;
      sel_q     <= 3'h0;
      port_q    <= PORT_32;
      waits_q   <= 4'h0;
      beat_q    <= 2'h0;
    end else if (accept && !refuse) begin
      line_q    <= (REQ.size == SIZE_LINE);
      burst_q   <= (REQ.size == SIZE_LINE) && sel_any && sel_cfg.burst_en;
      addr_q    <= (REQ.size == SIZE_LINE) ? {REQ.addr[31:LINE_LSB], 4'h0} : REQ.addr;
      size_q    <= REQ.size;
      write_q   <= REQ.write;
      xtype_q   <= REQ.xtype;
      wdata_q   <= REQ.wdata;
      ext_q     <= sel_cfg.ext_ack;
      sel_any_q <= sel_any;
      sel_q     <= sel_idx;
      port_q    <= sel_cfg.port;
      waits_q   <= sel_cfg.waits;
      beat_q    <= 2'h0;
    end else if (beat_end && !last_beat) begin
      beat_q                     <= beat_q + 2'h1;
      addr_q[LINE_LSB-1:WORD_LSB] <= beat_q + 2'h1;
    end
  end

  // Wait-state counter reloads for every beat
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      wcnt_q <= 4'h0;
    end else if (state_q == ST_START || beat_end) begin
      wcnt_q <= waits_q;
    end else if (state_q == ST_WAIT && wcnt_q != 4'h0) begin
      wcnt_q <= wcnt_q - 4'h1;
    end
  end

  // Write data of the current beat
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      data_o_q <= 32'h0000_0000;
    end else if (accept && !refuse) begin
      // Beat zero comes straight from the request; the captured copy is not loaded yet
      data_o_q <= REQ.wdata[31:0];
    end else if (state_d == ST_START || (state_d == ST_WAIT && beat_end)) begin
      data_o_q <= wdata_q[32*(beat_end && !last_beat ? beat_q + 2'h1 : beat_q) +: 32];
    end
  end

  // Response per beat, or an error pulse for a refused write
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end else begin
      rsp_valid_q <= refuse || beat_end;
      if (refuse) begin
        rsp_q <= '{data: 32'h0000_0000, beat: 2'h0, last: 1'b1, err: 1'b1};
      end else if (beat_end) begin
        rsp_q <= '{data: write_q ? 32'h0000_0000 : DATA_I, beat: beat_q, last: last_beat, err: 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus pins

  assign RSP_VALID          = rsp_valid_q;
  assign RSP                = rsp_q;
  assign ADDR               = addr_q;
  assign DATA_O             = data_o_q;
  assign DATA_OE            = write_q && (state_q == ST_START || state_q == ST_WAIT);
  assign XFER_START_N       = (state_q == ST_START) ? 1'b0 : RST_START_N;
  assign XFER_SIZE          = (line_q && !burst_q) ? SIZE_32 : size_q;
  assign XFER_RW            = (state_q == ST_IDLE) ? RST_RW : !write_q;
  // Only memory transfer types exist; no separate I/O cycle is ever issued
  assign XFER_TYPE          = xtype_q;
  assign XFER_IN_PROGRESS_N = (state_q == ST_START || state_q == ST_WAIT) ? 1'b0 : RST_TIP_N;
  assign OE_N               = !(state_q == ST_WAIT && !write_q && sel_any_q);
  assign WE_N               = !(state_q == ST_WAIT && write_q && sel_any_q);
  assign CS_PORT            = port_q;

  always_comb begin
    CS_N = '1;
    if ((state_q == ST_START || state_q == ST_WAIT) && sel_any_q) begin
      CS_N[sel_q] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0] wage_q;

  always_ff @(posedge CLOCK) begin
    if (!RESETN || state_q != ST_WAIT || beat_end) begin
      wage_q <= 4'h0;
    end else if (wage_q != WAIT_MAX) begin
      wage_q <= wage_q + 4'h1;
    end
  end

  chk_start_one_clock: assert property (@(posedge CLOCK) disable iff (!RESETN)
    !XFER_START_N |=> XFER_START_N && !XFER_IN_PROGRESS_N)
    else $error("start strobe longer than one clock");

  chk_size_follows: assert property (@(posedge CLOCK) disable iff (!RESETN)
    accept && !refuse && REQ.size != SIZE_LINE |=> XFER_SIZE == $past(REQ.size) && !XFER_START_N)
    else $error("size field does not match request");

  chk_dir_level: assert property (@(posedge CLOCK) disable iff (!RESETN)
    accept && !refuse |=> XFER_RW == !$past(REQ.write))
    else $error("direction wrong for transfer");

  chk_type_follows: assert property (@(posedge CLOCK) disable iff (!RESETN)
    accept && !refuse |=> XFER_TYPE == $past(REQ.xtype))
    else $error("transfer type not driven with address");

  chk_start_after_release: assert property (@(posedge CLOCK) disable iff (!RESETN)
    !XFER_START_N |-> $past(XFER_ACK_N))
    else $error("start while acknowledge still low");

  chk_two_clock_min: assert property (@(posedge CLOCK) disable iff (!RESETN)
    !XFER_START_N |-> !ack_now ##1 !XFER_IN_PROGRESS_N)
    else $error("transfer shorter than two clocks");

  chk_burst_tip_held: assert property (@(posedge CLOCK) disable iff (!RESETN)
    beat_end && burst_q && !last_beat |=> !XFER_IN_PROGRESS_N && XFER_START_N)
    else $error("in-progress broken inside burst");

  chk_burst_line_only: assert property (@(posedge CLOCK) disable iff (!RESETN)
    !XFER_START_N && XFER_SIZE == SIZE_LINE |-> line_q && burst_q)
    else $error("burst issued for non-line transfer");

  chk_split_no_burst: assert property (@(posedge CLOCK) disable iff (!RESETN)
    accept && !refuse && REQ.size == SIZE_LINE && !sel_cfg.burst_en |=> XFER_SIZE == SIZE_32)
    else $error("burst reached a select with bursts off");

  chk_cs_onehot: assert property (@(posedge CLOCK) disable iff (!RESETN)
    $onehot0(~CS_N) && (OE_N || WE_N))
    else $error("more than one select or strobe active");

  chk_boot_select: assert property (@(posedge CLOCK) disable iff (!RESETN)
    !CFG_CS[0].valid && accept |=> !CS_N[0])
    else $error("select zero missing before programming");

  chk_wait_count: assert property (@(posedge CLOCK) disable iff (!RESETN)
    ack_now && sel_any_q && !ext_q |-> wage_q == waits_q)
    else $error("wait states differ from setting");

  cov_burst_done:  cover property (@(posedge CLOCK) disable iff (!RESETN) beat_end && burst_q && last_beat);
  cov_split_line:  cover property (@(posedge CLOCK) disable iff (!RESETN) beat_end && line_q && !burst_q && last_beat);
  cov_protect_err: cover property (@(posedge CLOCK) disable iff (!RESETN) refuse);
  cov_long_wait:   cover property (@(posedge CLOCK) disable iff (!RESETN) ack_now && !ext_q && waits_q == WAIT_MAX);

endmodule

// >>> verilog/ssb_cs_slot.sv
// Address decoder of one chip select
`timescale 1ns/1ps
module ssb_cs_slot #(
  parameter int IDX = 0
) (
  input  ssb_pkg::ssb_cs_cfg_t cfg,
  input  wire logic [31:0]     group_base,
  input  wire logic [31:0]     addr,
  input  wire logic [1:0]      xtype,
  output logic                 hit
);
  import ssb_pkg::*;

  logic [31:0] base;
  logic [31:0] mask;
  logic        space_ok;
  logic        boot;

  generate
    if (IDX < FIXED_FIRST) begin : g_prog
      assign base = cfg.base;
      assign mask = cfg.mask;
    end else begin : g_fixed
      assign base = group_base + 32'(IDX - FIXED_FIRST) * FIXED_BLOCK;
      assign mask = ~(FIXED_BLOCK - 32'h0000_0001);
    end
  endgenerate

  // Until programmed, the lowest select answers everything so a boot memory can run
  assign boot     = (IDX == 0) && !cfg.valid;
  assign space_ok = (cfg.space == SPACE_ANY) || (cfg.space == xtype);
  assign hit      = boot || (cfg.valid && space_ok && ((addr & mask) == (base & mask)));

endmodule

// >>> verilog/ssb_pkg.sv
// Shared constants and carrier types for the system bus master and chip-select unit
package ssb_pkg;

  localparam int          NUM_CS      = 8;
  localparam int          FIXED_FIRST = 2;
  localparam logic [1:0]  BEAT_LAST   = 2'h3;
  localparam logic [3:0]  WAIT_MAX    = 4'hf;

  // Transfer size codes
  localparam logic [1:0]  SIZE_32     = 2'h0;
  localparam logic [1:0]  SIZE_8      = 2'h1;
  localparam logic [1:0]  SIZE_16     = 2'h2;
  localparam logic [1:0]  SIZE_LINE   = 2'h3;

  // Port width codes of a chip select
  localparam logic [1:0]  PORT_32     = 2'h0;
  localparam logic [1:0]  PORT_8      = 2'h1;
  localparam logic [1:0]  PORT_16     = 2'h2;

  // Address space code that matches every transfer type
  localparam logic [1:0]  SPACE_ANY   = 2'h0;

  // Fixed block of each upper chip select: 2M bytes
  localparam logic [31:0] FIXED_BLOCK = 32'h0020_0000;

  // Line burst address alignment
  localparam int          LINE_LSB    = 4;
  localparam int          WORD_LSB    = 2;

  // Idle levels of the bus outputs
  localparam logic        RST_START_N = 1'h1;
  localparam logic        RST_TIP_N   = 1'h1;
  localparam logic        RST_RW      = 1'h1;

  typedef struct packed {
    logic [31:0]  addr;
    logic [1:0]   size;
    logic         write;
    logic [1:0]   xtype;
    logic [127:0] wdata;
  } ssb_req_t;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] mask;
    logic [1:0]  port;
    logic [3:0]  waits;
    logic        ext_ack;
    logic [1:0]  space;
    logic        burst_en;
    logic        wprot;
    logic        valid;
  } ssb_cs_cfg_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  beat;
    logic        last;
    logic        err;
  } ssb_rsp_t;

endpackage
